// [bench/rscad_kbd_model.sv]
// keyboard and mouse controller model driving the two interrupt pins
// assumes the bench pulses fire for one cycle with a hold time
`timescale 1ns/1ps
module rscad_kbd_model (
  // clock and reset
  input logic clk_sys,
  input logic arst_n,
  // request from the bench and the host bus
  input logic [1:0] fire,
  input logic [7:0] hold,
  input rscad_pkg::rscad_cyc_t host_cyc,
  // interrupt pins
  output logic irq1_pin,
  output logic irq12_pin
);
  import rscad_pkg::*;
  logic [1:0] pin_r;
  logic [7:0] left_r [2];
  logic rd60;
  assign rd60 = host_cyc.valid && host_cyc.io && !host_cyc.write && host_cyc.addr[15:0] == 16'h0060;
  assign irq1_pin = pin_r[0];
  assign irq12_pin = pin_r[1];
  // a short hold stands for a controller that pulses instead of holding
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_r <= 2'h0;
      left_r[0] <= 8'h00;
      left_r[1] <= 8'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (fire[i]) begin
          pin_r[i] <= 1'b1;
          left_r[i] <= hold;
        end else if (rd60 || left_r[i] == 8'h01) begin
          pin_r[i] <= 1'b0;
          left_r[i] <= 8'h00;
        end else if (left_r[i] != 8'h00) left_r[i] <= left_r[i] - 8'h01;
      end
    end
  end
endmodule : rscad_kbd_model

// [bench/rscad_top_monitor.sv]
// concurrent checks for the rom select / cache attribute decode top
// assumes binding onto rscad_top, one clock, async active-low reset
`timescale 1ns/1ps
module rscad_top_monitor (
  // clock and reset
  input logic clk_sys,
  input logic arst_n,
  // apb
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // host side
  input rscad_pkg::rscad_cyc_t host_cyc,
  input rscad_pkg::rscad_ext_t ext_cfg,
  input logic irq1_pin,
  input logic irq12_pin,
  input logic irq1_out,
  input logic irq12_out,
  input rscad_pkg::rscad_dec_t dec_out,
  input logic rom_chip_select_n
);
  import rscad_pkg::*;
  logic [7:0] rs_r;
  logic [7:0] cr_r;
  logic wr_rs;
  logic mem;
  logic eseg;
  logic clr60;
  logic [4:0] rw;
  logic exp_cs_n;
  logic exp_l1;
  logic exp_l2;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // decode expected from shadowed registers, old value at a write edge
  assign wr_rs = psel && penable && pwrite && pstrb[0] && paddr == 12'h0b4;
  assign mem = host_cyc.valid && !host_cyc.io && host_cyc.addr[23:20] == 4'h0;
  assign eseg = mem && host_cyc.addr[19:16] == 4'he;
  assign clr60 = host_cyc.valid && host_cyc.io && !host_cyc.write && host_cyc.addr[15:0] == 16'h0060;
  assign rw = host_cyc.addr[19:15] - 5'h18;
  assign exp_cs_n = !(mem && rw < 5'h06 && rs_r[rw[2:0]] && (!host_cyc.write || ext_cfg.rom_write_allow));
  assign exp_l1 = mem && host_cyc.addr[19:18] == 2'h3 && cr_r[{2'h1, host_cyc.addr[17:16]}];
  assign exp_l2 = eseg && cr_r[host_cyc.addr[15:14]] && ext_cfg.eseg_shadow_en[host_cyc.addr[15:14]]
    && !ext_cfg.hp_cache_module;
  // shadow copies of both registers, fed from the bus like software sees them
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) rs_r <= 8'hc0;
    else if (wr_rs) rs_r <= pwdata[7:0];
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) cr_r <= 8'h00;
    else if (psel && penable && pwrite && pstrb[0] && paddr == 12'h0b8) cr_r <= pwdata[7:0];
  end
  // eight quiet pin cycles rule out a fresh edge racing the clear
  sequence s_quiet1;
    (!irq1_pin) [*8];
  endsequence
  sequence s_quiet12;
    (!irq12_pin) [*8];
  endsequence
  a_rom_select: assert property (1'b1 |=> rom_chip_select_n == $past(exp_cs_n))
    else $error("rom select differs from decode");
  a_l1_attr: assert property (mem |=> dec_out.l1_cacheable == $past(exp_l1))
    else $error("l1 attribute wrong");
  a_l2_attr: assert property (mem |=> dec_out.l2_cacheable == $past(exp_l2))
    else $error("l2 attribute wrong");
  a_wp_attr: assert property (mem |=> dec_out.write_protect == $past(eseg && ext_cfg.eseg_wp_en))
    else $error("write protect wrong");
  a_kbd_pass: assert property ((rs_r[6] && irq1_pin) [*8] |-> irq1_out)
    else $error("keyboard irq not passed");
  a_mouse_pass: assert property ((rs_r[7] && irq12_pin) [*8] |-> irq12_out)
    else $error("mouse irq not passed");
  a_kbd_hold: assert property (!rs_r[6] && $past(!rs_r[6]) && !wr_rs && !clr60 && irq1_out |=> irq1_out)
    else $error("keyboard latch dropped");
  a_mouse_hold: assert property (!rs_r[7] && $past(!rs_r[7]) && !wr_rs && !clr60 && irq12_out |=> irq12_out)
    else $error("mouse latch dropped");
  a_kbd_clear: assert property (s_quiet1 ##0 (clr60 && !rs_r[6]) |=> !irq1_out)
    else $error("keyboard latch not cleared");
  a_mouse_clear: assert property (s_quiet12 ##0 (clr60 && !rs_r[7]) |=> !irq12_out)
    else $error("mouse latch not cleared");
endmodule : rscad_top_monitor

bind rscad_top rscad_top_monitor u_mon (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .host_cyc, .ext_cfg, .irq1_pin, .irq12_pin, .irq1_out, .irq12_out, .dec_out,
  .rom_chip_select_n);

// [bench/rscad_top_test.sv]
// self-checking bench: apb register access, random host decode, irq latching
// assumes rscad_pkg compiled first; monitor bound separately
`timescale 1ns/1ps
module rscad_top_test;
  import rscad_pkg::*;
  logic clk_sys;
  logic arst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rscad_cyc_t host_cyc;
  rscad_ext_t ext_cfg;
  logic irq1_pin;
  logic irq12_pin;
  logic irq1_out;
  logic irq12_out;
  rscad_dec_t dec_out;
  logic rom_chip_select_n;
  logic [1:0] fire;
  logic [7:0] hold;
  logic [7:0] rs;
  logic [7:0] cr;
  int fail_count;
  int checked;
  rscad_top dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .host_cyc, .ext_cfg, .irq1_pin, .irq12_pin, .irq1_out, .irq12_out, .dec_out, .rom_chip_select_n);
  rscad_kbd_model u_kbd (.clk_sys, .arst_n, .fire, .hold, .host_cyc, .irq1_pin, .irq12_pin);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task results;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // one apb transfer; waits for pready, no wait count assumed
  task apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] s, output logic [32:0] r);
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    logic [32:0] r;
    apb(a, 1'b1, d, s, r);
    if (s[0] && a == 12'h0b4) rs = d;
    if (s[0] && a == 12'h0b8) cr = d;
  endtask : wr
  task rd(input logic [11:0] a, input logic [32:0] ex);
    logic [32:0] r;
    apb(a, 1'b0, 8'h00, 4'h0, r);
    check(r[31:0], ex[31:0]);
    check({31'h0, r[32]}, {31'h0, ex[32]});
  endtask : rd
  // reference decode, written with plain address arithmetic
  function automatic rscad_dec_t model(input rscad_cyc_t c, input rscad_ext_t e);
    rscad_dec_t m;
    int a;
    logic mem;
    logic es;
    a = {12'h0, c.addr[19:0]};
    mem = c.valid && !c.io && c.addr[23:20] == 4'h0;
    es = mem && a >= 20'he0000 && a < 20'hf0000;
    m.valid = c.valid && !c.io;
    m.rom_chip_select_n = !(mem && a >= 20'hc0000 && a < 20'hf0000 && rs[(a - 20'hc0000) / 20'h08000]
      && (!c.write || e.rom_write_allow));
    m.l1_cacheable = mem && a >= 20'hc0000 && cr[4 + (a - 20'hc0000) / 20'h10000];
    m.l2_cacheable = es && cr[(a - 20'he0000) / 20'h04000] && e.eseg_shadow_en[(a - 20'he0000) / 20'h04000]
      && !e.hp_cache_module;
    m.write_protect = es && e.eseg_wp_en;
    return m;
  endfunction : model
  // back-to-back random host cycles, one result compared per clock
  task host(input int n);
    rscad_cyc_t c;
    rscad_ext_t e;
    rscad_dec_t prev;
    prev = model('0, '0);
    repeat (n) begin
      c = {$urandom % 4 != 0, $urandom % 8 == 0, $urandom % 2 == 1, ($urandom % 8 == 0) ? 4'h1 : 4'h0,
        20'hc0000 + 20'($urandom % 32'h40000)};
      e = 7'($urandom);
      @(posedge clk_sys);
      host_cyc <= c;
      ext_cfg <= e;
      #1 check({27'h0, dec_out}, {27'h0, prev});
      check({31'h0, rom_chip_select_n}, {31'h0, prev.rom_chip_select_n});
      prev = model(c, e);
    end
    @(posedge clk_sys);
    host_cyc <= '0;
    // the last cycle of the run is decoded too
    #1 check({27'h0, dec_out}, {27'h0, prev});
  endtask : host
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, pstrb, host_cyc, ext_cfg, fire, hold} = '0;
    {fail_count, checked, rs, cr} = {64'h0, 8'hc0, 8'h00};
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    void'($urandom(64947));
    rd(12'h0b4, 33'h0c0);
    rd(12'h0b8, 33'h000);
    rd(12'h000, 33'h100000000);
    wr(12'h0b4, 8'h3f, 4'he);
    wr(12'h0bc, 8'h55, 4'hf);
    rd(12'h0b4, {25'h0, rs});
    repeat (6) begin
      wr(12'h0b4, 8'($urandom), 4'hf);
      wr(12'h0b8, 8'($urandom), 4'hf);
      rd(12'h0b8, {25'h0, cr});
      host(300);
    end
    // pass-through first, then latched with a pin pulse shorter than the wait
    for (int m = 0; m < 2; m++) begin
      wr(12'h0b4, m ? 8'h00 : 8'hc0, 4'h1);
      for (int i = 0; i < 2; i++) begin
        @(posedge clk_sys);
        fire <= 2'h1 << i;
        hold <= m ? 8'd4 : 8'd20;
        @(posedge clk_sys);
        fire <= 2'h0;
        repeat (12) @(posedge clk_sys);
        #1 check({31'h0, i ? irq12_out : irq1_out}, 32'h1);
        repeat (20) @(posedge clk_sys);
        #1 check({31'h0, i ? irq12_out : irq1_out}, 32'(m));
        @(posedge clk_sys);
        host_cyc <= {3'h6, 24'h000060};
        @(posedge clk_sys);
        host_cyc <= '0;
        repeat (2) @(posedge clk_sys);
        #1 check({31'h0, i ? irq12_out : irq1_out}, 32'h0);
      end
    end
    results;
  end
  initial begin
    #100000;
    fail_count++;
    results;
  end
endmodule : rscad_top_test

// [rtl/rscad_defs.svh]
// named constants for the rom select / cache attribute decode block
// assumes inclusion by bare name from the package and the modules
`ifndef RSCAD_DEFS_SVH
`define RSCAD_DEFS_SVH

// register indices and their apb byte addresses (index times four)
`define RSCAD_IDX_ROMSEL 8'h2d
`define RSCAD_IDX_CACHE1 8'h2e
`define RSCAD_ADDR_ROMSEL 12'h0b4
`define RSCAD_ADDR_CACHE1 12'h0b8
`define RSCAD_ADDR_W 12

// reset values
`define RSCAD_RST_ROMSEL 8'hc0
`define RSCAD_RST_CACHE1 8'h00

// field positions in the rom select register
`define RSCAD_BIT_MOUSE_NOLATCH 7
`define RSCAD_BIT_KBD_NOLATCH 6
`define RSCAD_ROMEN_HI 5
`define RSCAD_ROMEN_LO 0

// field positions in the cacheable range register
`define RSCAD_L1_HI 7
`define RSCAD_L1_LO 4
`define RSCAD_L2E_HI 3
`define RSCAD_L2E_LO 0

// host address decode
`define RSCAD_HADDR_W 24
`define RSCAD_HI_ZERO 4'h0
`define RSCAD_PORT_KBD_DATA 16'h0060
`define RSCAD_ROM_WIN_BASE 5'h18
`define RSCAD_ROM_WIN_CNT 5'h06
`define RSCAD_L1_AREA_BASE 4'hc
`define RSCAD_L2_AREA_BASE 6'h38
`define RSCAD_L2_AREA_CNT 6'h04

// interrupt inputs handled by the latch: 0 keyboard, 1 mouse
`define RSCAD_IRQ_KBD 0
`define RSCAD_IRQ_MOUSE 1

`endif

// [rtl/rscad_irq_latch.sv]
// one interrupt line: pin synchroniser, glitch filter and optional latch
// assumes irq_pin is asynchronous to clk_sys; clear is a one-cycle pulse
`timescale 1ns/1ps
module rscad_irq_latch (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // interrupt pin and control
  input wire logic irq_pin,
  input wire logic no_latch,
  input wire logic clear,
  // interrupt toward the controller
  output logic irq_out
);
  import rscad_pkg::*;

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic filt_r;
  logic filt_prev_r;
  logic held_r;
  logic held_nxt;
  logic rise;

  // three-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= irq_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a change counts only once two stages agree, so one-cycle spikes die here
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      filt_r <= 1'b0;
      filt_prev_r <= 1'b0;
    end else begin
      if (sync2_r == sync3_r) begin
        filt_r <= sync3_r;
      end
      filt_prev_r <= filt_r;
    end
  end

  // edge capture: a level set would re-arm at once while the pin is still high
  assign rise = filt_r & ~filt_prev_r;
  assign held_nxt = rise | (held_r & ~clear); // R4 R3

  // latch only works while latching is selected; a new edge beats a clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      held_r <= 1'b0;
    end else if (no_latch) begin
      held_r <= 1'b0;
    end else begin
      held_r <= held_nxt; // R4
    end
  end

  // output register: pass-through follows the filtered pin
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= no_latch ? filt_r : held_nxt; // R1 R2
    end
  end
endmodule : rscad_irq_latch

// [rtl/rscad_pkg.sv]
// types shared by the rom select / cache attribute decode block
// assumes rscad_defs.svh is on the include path
package rscad_pkg;
  `include "rscad_defs.svh"

  // one host processor bus cycle as seen by the decoder
  typedef struct packed {
    logic valid;
    logic io;
    logic write;
    logic [`RSCAD_HADDR_W-1:0] addr;
  } rscad_cyc_t;

  // registered decode result for the last cycle presented
  typedef struct packed {
    logic valid;
    logic rom_chip_select_n;
    logic l1_cacheable;
    logic l2_cacheable;
    logic write_protect;
  } rscad_dec_t;

  // settings that live in other index registers of the chipset
  typedef struct packed {
    logic rom_write_allow;
    logic eseg_wp_en;
    logic [3:0] eseg_shadow_en;
    logic hp_cache_module;
  } rscad_ext_t;
endpackage : rscad_pkg

// [rtl/rscad_top.sv]
// rom chip select, irq latch control and cacheability decode with an apb slave
// assumes one clock clk_sys, asynchronous active-low reset, host cycles
// presented as a struct for one cycle, other-register settings as levels
`timescale 1ns/1ps
`include "rscad_defs.svh"

// How it works
// [R1] mouse irq latched when its bit is zero
// [R2] keyboard irq latched when its bit is zero
// [R3] io read of port 60h clears latches
// [R4] latch holds irq until cleared by read
// [R5] six enable bits gate rom select on reads
// [R6] bits map ascending to 32KB windows from C0000h
// [R7] rom writes need the external write permit
// [R8] disabled window never asserts rom select
// [R9] four bits mark L1 cacheable areas
// [R10] L1 bits cover 64KB areas C0000h to FFFFFh
// [R11] four E-segment L2 bits, only when shadowed
// [R12] L2 bits cover 16KB areas from E0000h
// [R13] E-segment write protected when protection enabled
// [R14] L2 bits ignored with high-performance cache module
module rscad_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RSCAD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host processor cycles
  input wire rscad_pkg::rscad_cyc_t host_cyc,
  // settings held in other registers of the chipset
  input wire rscad_pkg::rscad_ext_t ext_cfg,
  // interrupt pins and their outputs
  input wire logic irq1_pin,
  input wire logic irq12_pin,
  output logic irq1_out,
  output logic irq12_out,
  // decode results
  output rscad_pkg::rscad_dec_t dec_out,
  output logic rom_chip_select_n
);
  import rscad_pkg::*;

  // software-visible registers
  logic [7:0] romsel_r;
  logic [7:0] cache1_r;

  // apb side
  logic [31:0] prdata_r;
  logic setup_phase;
  logic access_phase;
  logic hit_romsel;
  logic hit_cache1;
  logic mapped;
  logic wr_en;

  // interrupt side
  logic port60_rd;
  logic [1:0] irq_pins;
  logic [1:0] irq_no_latch;
  logic [1:0] irq_q;

  // decode side
  rscad_dec_t dec_r;
  rscad_dec_t dec_nxt;
  logic [2:0] rom_idx;
  logic rom_in;
  logic [1:0] l1_idx;
  logic l1_in;
  logic [1:0] l2_idx;
  logic l2_in;
  logic rom_en_bit;
  logic l1_bit;
  logic l2_bit;

  // true when the area index sel lies inside a run of cnt equal-size areas from base
  function automatic logic in_run(input logic [5:0] sel, input logic [5:0] base, input logic [5:0] cnt);
    logic [5:0] off;
    off = sel - base;
    in_run = (sel >= base) && (off < cnt);
  endfunction : in_run

  // the region decode is only valid below 1MB; the upper nibble must be zero
  function automatic logic below_1m(input logic [`RSCAD_HADDR_W-1:0] a);
    below_1m = (a[`RSCAD_HADDR_W-1:20] == `RSCAD_HI_ZERO);
  endfunction : below_1m

  // apb address decode, register index times four gives the byte address
  function automatic logic addr_is(input logic [`RSCAD_ADDR_W-1:0] a, input logic [`RSCAD_ADDR_W-1:0] r);
    addr_is = (a == r);
  endfunction : addr_is

  // ---------------------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------------------

  // phases of a transfer
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_romsel = addr_is(paddr, `RSCAD_ADDR_ROMSEL);
  assign hit_cache1 = addr_is(paddr, `RSCAD_ADDR_CACHE1);
  assign mapped = hit_romsel | hit_cache1;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_phase & ~mapped;

  // only the low byte lane carries register data
  assign wr_en = access_phase & pwrite & pstrb[0];

  // read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      if (hit_romsel) begin
        prdata_r <= {24'h00_0000, romsel_r};
      end else if (hit_cache1) begin
        prdata_r <= {24'h00_0000, cache1_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end
  assign prdata = prdata_r;

  // rom select and irq latch control register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      romsel_r <= `RSCAD_RST_ROMSEL; // R1 R2
    end else if (wr_en && hit_romsel) begin
      romsel_r <= pwdata[7:0]; // R5
    end
  end

  // cacheable address range register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cache1_r <= `RSCAD_RST_CACHE1; // R9 R11
    end else if (wr_en && hit_cache1) begin
      cache1_r <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt latches
  // ---------------------------------------------------------------------------

  // an io read of the keyboard data port is the clearing event for both
  assign port60_rd = host_cyc.valid & host_cyc.io & ~host_cyc.write &
                     (host_cyc.addr[15:0] == `RSCAD_PORT_KBD_DATA); // R3

  assign irq_pins[`RSCAD_IRQ_KBD] = irq1_pin;
  assign irq_pins[`RSCAD_IRQ_MOUSE] = irq12_pin;
  assign irq_no_latch[`RSCAD_IRQ_KBD] = romsel_r[`RSCAD_BIT_KBD_NOLATCH]; // R2
  assign irq_no_latch[`RSCAD_IRQ_MOUSE] = romsel_r[`RSCAD_BIT_MOUSE_NOLATCH]; // R1

  // one latch per interrupt line
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
      rscad_irq_latch u_latch (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .irq_pin(irq_pins[gi]),
        .no_latch(irq_no_latch[gi]),
        .clear(port60_rd),
        .irq_out(irq_q[gi])
      );
    end
  endgenerate

  assign irq1_out = irq_q[`RSCAD_IRQ_KBD];
  assign irq12_out = irq_q[`RSCAD_IRQ_MOUSE];

  // ---------------------------------------------------------------------------
  // memory cycle decode
  // ---------------------------------------------------------------------------

  // rom windows: 32KB each, six of them starting at C0000h
  assign rom_in = below_1m(host_cyc.addr) &&
                  in_run({1'b0, host_cyc.addr[19:15]}, {1'b0, `RSCAD_ROM_WIN_BASE},
                         {1'b0, `RSCAD_ROM_WIN_CNT}); // R6
  assign rom_idx = 3'(host_cyc.addr[19:15] - `RSCAD_ROM_WIN_BASE); // R6
  assign rom_en_bit = romsel_r[`RSCAD_ROMEN_LO + 32'(rom_idx)]; // R5 R8

  // L1 areas: 64KB each, C0000h through FFFFFh
  assign l1_in = below_1m(host_cyc.addr) && (host_cyc.addr[19:16] >= `RSCAD_L1_AREA_BASE); // R10
  assign l1_idx = 2'(host_cyc.addr[19:16] - `RSCAD_L1_AREA_BASE); // R10
  assign l1_bit = cache1_r[`RSCAD_L1_LO + 32'(l1_idx)]; // R9

  // E-segment L2 areas: 16KB each from E0000h
  assign l2_in = below_1m(host_cyc.addr) &&
                 in_run(host_cyc.addr[19:14], `RSCAD_L2_AREA_BASE, `RSCAD_L2_AREA_CNT); // R12
  assign l2_idx = 2'(host_cyc.addr[19:14] - `RSCAD_L2_AREA_BASE); // R12
  assign l2_bit = cache1_r[`RSCAD_L2E_LO + 32'(l2_idx)]; // R11

  // next decode result; io cycles and idle cycles decode to nothing
  always_comb begin
    dec_nxt = '0;
    dec_nxt.rom_chip_select_n = 1'b1;
    if (host_cyc.valid && !host_cyc.io) begin
      dec_nxt.valid = 1'b1;
      // reads need only the enable, writes also need the external permit
      if (rom_in && rom_en_bit && (!host_cyc.write || ext_cfg.rom_write_allow)) begin // R5 R7 R8
        dec_nxt.rom_chip_select_n = 1'b0;
      end
      dec_nxt.l1_cacheable = l1_in & l1_bit; // R9
      // shadowing gates L2, and a high-performance module overrides all
      dec_nxt.l2_cacheable = l2_in & l2_bit & ext_cfg.eseg_shadow_en[l2_idx] &
                             ~ext_cfg.hp_cache_module; // R11 R14
      dec_nxt.write_protect = l2_in & ext_cfg.eseg_wp_en; // R13
    end
  end

  // decode result registered: valid one clock after the cycle is presented
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dec_r <= '{valid: 1'b0, rom_chip_select_n: 1'b1, l1_cacheable: 1'b0,
                 l2_cacheable: 1'b0, write_protect: 1'b0};
    end else begin
      dec_r <= dec_nxt;
    end
  end

  assign dec_out = dec_r;
  assign rom_chip_select_n = dec_r.rom_chip_select_n;
endmodule : rscad_top
